// *** gpio_port.v ***
// Behaviour
// - Unclaimed non-analog pins act as software GPIO
// - Port 0 and port 2 latches byte and bit addressable; other port registers byte only
// - Writes captured in held output latch
// - Normal reads return sampled pin levels
// - Read-modify-write byte ops read latch
// - Bit move/clear/set read latch bits
`include "gpio_port_defines.vh"
`timescale 1ns/100ps
`default_nettype none
module gpio_port (
   input  wire       CLK,
   input  wire       RST,
   input  wire       CE,
   input  wire [7:0] ADDR,
   input  wire       BIT_MODE,
   input  wire       WR,
   input  wire       RD,
   input  wire       RMW,
   input  wire [7:0] WDATA,
   input  wire       WBIT,
   output reg  [7:0] RDATA,
   output reg        RBIT,
   input  wire [7:0] P0_IN,
   output reg  [7:0] P0_OUT,
   output reg  [7:0] P0_OE,
   input  wire       P2_IN,
   output reg        P2_OUT,
   output reg        P2_OE,
   input  wire [7:0] XBAR_CLAIM0,
   input  wire [7:0] XBAR_DATA0,
   input  wire [7:0] XBAR_OEN0,
   output reg  [7:0] P1_BYPASS
);
   reg  [7:0] port0_latch_ff;
   reg  [7:0] port2_latch_ff;
   reg  [7:0] port0_drive_ff;
   reg  [7:0] port1_bypass_ff;
   reg  [7:0] port0_kind_ff;
   wire [7:0] p0_sync;
   wire [7:0] p2_sync;
   reg  [7:0] rd_src;
   reg  [7:0] nxt_byte;
   reg  [7:0] nxt_rdata;
   reg        nxt_rbit;
   reg  [7:0] cur_latch;
   reg  [7:0] p0_pin_val;
   reg  [7:0] p0_drv;
   integer    i;

   ////////////////////////////////////////////////////////////////////////
   function [7:0] byte_of_bit;
      input [7:0] a;
      begin
         byte_of_bit = {a[7:`BIT_BASE_POS], {`BIT_BASE_POS{1'b0}}};
      end
   endfunction

   wire [7:0] eff_addr = BIT_MODE ? byte_of_bit(ADDR) : ADDR;
   wire [2:0] bit_sel  = ADDR[`BIT_SEL_MSB:0];

   ////////////////////////////////////////////////////////////////////////
   pin_sync #(.WIDTH(8)) u_sync0 (
      .clk  (CLK),
      .rst  (RST),
      .ce   (CE),
      .din  (P0_IN),
      .dout (p0_sync)
   );
   pin_sync #(.WIDTH(8)) u_sync2 (
      .clk  (CLK),
      .rst  (RST),
      .ce   (CE),
      .din  ({7'h00, P2_IN}),
      .dout (p2_sync)
   );

   ////////////////////////////////////////////////////////////////////////
   always @* begin
      p0_pin_val = p0_sync & port0_kind_ff;
      cur_latch  = 8'h00;
      rd_src     = 8'h00;
      case (eff_addr)
         `ADDR_PORT0_LATCH : begin
            cur_latch = port0_latch_ff;
            rd_src    = RMW ? port0_latch_ff : p0_pin_val;
         end
         `ADDR_PORT2_LATCH : begin
            cur_latch = port2_latch_ff;
            rd_src    = RMW ? port2_latch_ff : (p2_sync & `PORT2_MASK);
         end
         `ADDR_PORT0_DRIVE : begin
            cur_latch = port0_drive_ff;
            rd_src    = port0_drive_ff;
         end
         `ADDR_PORT1_BYPASS: begin
            cur_latch = port1_bypass_ff;
            rd_src    = port1_bypass_ff;
         end
         `ADDR_PORT0_KIND  : begin
            cur_latch = port0_kind_ff;
            rd_src    = port0_kind_ff;
         end
         default           : begin
            cur_latch = 8'h00;
            rd_src    = 8'h00;
         end
      endcase
      nxt_byte = cur_latch;
      if (BIT_MODE)
         nxt_byte[bit_sel] = WBIT;
      else
         nxt_byte = WDATA;
      nxt_rdata = RD ? rd_src : RDATA;
      nxt_rbit  = RD ? rd_src[bit_sel] : RBIT;
   end

   ////////////////////////////////////////////////////////////////////////
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         port0_latch_ff  <= `RST_PORT0_LATCH;
         port2_latch_ff  <= `RST_PORT2_LATCH;
         port0_drive_ff  <= `RST_PORT0_DRIVE;
         port1_bypass_ff <= `RST_PORT1_BYPASS;
         port0_kind_ff   <= `RST_PORT0_KIND;
         RDATA           <= 8'h00;
         RBIT            <= 1'b0;
      end else if (CE) begin
         RDATA <= nxt_rdata;
         RBIT  <= nxt_rbit;
         if (WR) begin
            case (eff_addr)
               `ADDR_PORT0_LATCH : port0_latch_ff  <= nxt_byte;
               `ADDR_PORT2_LATCH : port2_latch_ff  <= nxt_byte & `PORT2_MASK;
               `ADDR_PORT0_DRIVE : port0_drive_ff  <= nxt_byte;
               `ADDR_PORT1_BYPASS: port1_bypass_ff <= nxt_byte;
               `ADDR_PORT0_KIND  : port0_kind_ff   <= nxt_byte;
               default           : port0_kind_ff   <= port0_kind_ff;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drive
   always @* begin
      p0_drv = 8'h00;
      for (i = 0; i < 8; i = i + 1)
         p0_drv[i] = XBAR_CLAIM0[i] ? XBAR_DATA0[i] : port0_latch_ff[i];
   end

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         P0_OUT    <= 8'h00;
         P0_OE     <= 8'h00;
         P2_OUT    <= 1'b0;
         P2_OE     <= 1'b0;
         P1_BYPASS <= 8'h00;
      end else if (CE) begin
         for (i = 0; i < 8; i = i + 1) begin
            P0_OUT[i] <= 1'b0;
            P0_OE[i]  <= port0_kind_ff[i] &
                         ~(XBAR_CLAIM0[i] & XBAR_OEN0[i]) &
                         (~p0_drv[i] | port0_drive_ff[i]);
            if (port0_drive_ff[i])
               P0_OUT[i] <= p0_drv[i];
         end
         P2_OUT    <= 1'b0;
         P2_OE     <= ~port2_latch_ff[0];
         P1_BYPASS <= port1_bypass_ff;
      end
   end
endmodule // gpio_port
`default_nettype wire

// *** gpio_port_defines.vh ***
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH
// Register addresses
`define ADDR_PORT0_LATCH    8'h80
`define ADDR_PORT2_LATCH    8'hA0
`define ADDR_PORT0_DRIVE    8'hA4
`define ADDR_PORT1_BYPASS   8'hD5
`define ADDR_PORT0_KIND     8'hF1
// Reset values
`define RST_PORT0_LATCH     8'hFF
`define RST_PORT2_LATCH     8'h01
`define RST_PORT0_DRIVE     8'h00
`define RST_PORT1_BYPASS    8'h00
`define RST_PORT0_KIND      8'hFF
// Port 2 writable mask
`define PORT2_MASK          8'h01
// Bit address split
`define BIT_BASE_POS        3
`define BIT_SEL_MSB         2
`endif

// *** gpio_port_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module gpio_port_sva (
   input wire logic       CLK, RST, CE, BIT_MODE, WR, RD, RMW, WBIT, RBIT, P2_OUT, P2_OE,
   input wire logic [7:0] ADDR, WDATA, RDATA, P0_OE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   a_p2_od_low: assert property (P2_OUT == 1'h0) else $error("p2 drives high");
   a_rdata_hold: assert property (!RD |=> $stable(RDATA)) else $error("rdata moved");
   a_unmapped_zero: assert property (RD && CE && !BIT_MODE && ADDR == 8'h10
      |=> RDATA == 8'h00) else $error("unmapped read");
   a_p2_read_mask: assert property (RD && CE && !BIT_MODE && ADDR == 8'hA0
      |=> RDATA[7:1] == 7'h00) else $error("p2 upper bits");
   a_latch_readback: assert property (WR && CE && !BIT_MODE && ADDR == 8'h80 ##1 RD && CE
      && RMW && !BIT_MODE && ADDR == 8'h80 |=> RDATA == $past(WDATA, 2)) else $error("latch");
   a_bit_readback: assert property (WR && CE && BIT_MODE && ADDR == 8'h80 ##1 RD && CE
      && RMW && BIT_MODE && ADDR == 8'h80 |=> RBIT == $past(WBIT, 2)) else $error("bit");
   a_p2_oe_latch: assert property (WR && CE && !BIT_MODE && ADDR == 8'hA0 |=> ##1
      ($past(WDATA, 2) & 8'h01) != {7'h00, P2_OE}) else $error("p2 oe");
   a_ce_freeze: assert property (!CE |=> $stable(RDATA) && $stable(P0_OE)
      && $stable(P2_OE)) else $error("ce low changed state");
   cover property (RD && RMW && BIT_MODE);
   cover property (WR && !CE);
   cover property (WR && ADDR == 8'hA0);
endmodule // gpio_port_sva
bind gpio_port gpio_port_sva gpio_port_sva_inst (.*);
`default_nettype wire

// *** gpio_port_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module gpio_port_tb;
   logic       clk = 0, rst = 1, ce = 1, bm = 0, wr = 0, rd = 0, rmw = 0, wbit = 0;
   logic [7:0] addr = 0, wdata = 0, pull_en = 0, xclaim = 0, xdata = 0, xoen = 0;
   wire  [7:0] rdata, p0_in, p0_out, p0_oe, p1_bypass;
   wire        rbit, p2_in, p2_out, p2_oe;
   int         fail_count = 0, samples_checked = 0, cycles = 0;
   always #5 clk = ~clk;
   gpio_port gpio_port_inst (.CLK(clk), .RST(rst), .CE(ce), .ADDR(addr), .BIT_MODE(bm),
      .WR(wr), .RD(rd), .RMW(rmw), .WDATA(wdata), .WBIT(wbit), .RDATA(rdata), .RBIT(rbit),
      .P0_IN(p0_in), .P0_OUT(p0_out), .P0_OE(p0_oe), .P2_IN(p2_in), .P2_OUT(p2_out),
      .P2_OE(p2_oe), .XBAR_CLAIM0(xclaim), .XBAR_DATA0(xdata), .XBAR_OEN0(xoen),
      .P1_BYPASS(p1_bypass));
   pin_board pin_board_inst (.p0_out(p0_out), .p0_oe(p0_oe), .pull_en(pull_en),
      .p2_out(p2_out), .p2_oe(p2_oe), .p0_in(p0_in), .p2_in(p2_in));
   ////////////////////////////////////////////////////////////////
   task automatic chk8(input logic [7:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Strobes stay up between back-to-back requests; settle drops them
   task automatic wr_op(input logic [7:0] a, d, input logic b);
      {addr, wdata, wbit, bm, wr, rd} = {a, d, d[0], b, 1'h1, 1'h0};
      @(posedge clk);
      #1;
   endtask
   task automatic rd_op(input logic [7:0] a, exp, input logic b, m);
      {addr, bm, rmw, rd, wr} = {a, b, m, 1'h1, 1'h0};
      @(posedge clk);
      #1;
      chk8(b ? {7'h00, rbit} : rdata, exp);
   endtask
   task automatic settle;
      {wr, rd} = 2'h0;
      repeat (5) @(posedge clk);
      #1;
   endtask
   task automatic t_regs;
      rd_op(8'h80, 8'hFF, 0, 1);
      rd_op(8'hA0, 8'h01, 0, 1);
      rd_op(8'hA4, 8'h00, 0, 0);
      rd_op(8'hD5, 8'h00, 0, 0);
      rd_op(8'hF1, 8'hFF, 0, 0);
      rd_op(8'h10, 8'h00, 0, 0);
      wr_op(8'hD5, 8'h7F, 0);
      settle;
      chk8(p1_bypass, 8'h7F);
      $display("regs done");
   endtask
   task automatic t_pins;
      pull_en = 8'h04;
      wr_op(8'h80, 8'hBC, 0);
      rd_op(8'h80, 8'hBC, 0, 1);
      settle;
      rd_op(8'h80, 8'hB8, 0, 0);
      wr_op(8'hF1, 8'h7F, 0);
      settle;
      rd_op(8'h80, 8'h38, 0, 0);
      $display("pins done");
   endtask
   task automatic t_bits;
      wr_op(8'h80, 8'h01, 1);
      rd_op(8'h80, 8'h01, 1, 1);
      rd_op(8'h80, 8'hBD, 0, 1);
      settle;
      rd_op(8'h82, 8'h00, 1, 0);
      rd_op(8'h82, 8'h01, 1, 1);
      ce = 0;
      wr_op(8'h80, 8'h00, 0);
      ce = 1;
      rd_op(8'h80, 8'hBD, 0, 1);
      $display("bits done");
   endtask
   task automatic t_drive;
      pull_en = 8'h00;
      wr_op(8'hA4, 8'hFF, 0);
      settle;
      chk8(p0_oe, 8'h7F);
      chk8(p0_out & p0_oe, 8'h3D);
      wr_op(8'hA0, 8'hFF, 0);
      rd_op(8'hA0, 8'h01, 0, 1);
      wr_op(8'hA0, 8'h00, 1);
      settle;
      chk8({7'h00, p2_oe}, 8'h01);
      rd_op(8'hA0, 8'h00, 0, 0);
      $display("drive done");
   endtask
   // Crossbar owns pin 0: pins read live, latch kept for read-modify-write
   task automatic t_xbar;
      {xclaim, xdata, xoen} = {8'h01, 8'h00, 8'h00};
      settle;
      chk8(p0_out, 8'hBC);
      rd_op(8'h80, 8'h3C, 0, 0);
      rd_op(8'h80, 8'hBD, 0, 1);
      xoen = 8'h01;
      settle;
      chk8(p0_oe, 8'h7E);
      rd_op(8'h80, 8'h3D, 0, 0);
      xclaim = 8'h00;
      settle;
      chk8(p0_out, 8'hBD);
      $display("xbar done");
   endtask
   task automatic close_out;
      $display("compares %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk) if (++cycles == 2000) begin
      fail_count++;
      close_out;
   end
   initial begin
      repeat (12) @(posedge clk);
      #1 rst = 0;
      t_regs;
      t_pins;
      t_bits;
      t_drive;
      t_xbar;
      close_out;
   end
endmodule // gpio_port_tb
`default_nettype wire

// *** pin_board.sv ***
`timescale 1ns/100ps
`default_nettype none
module pin_board (
   input  wire logic [7:0] p0_out, p0_oe, pull_en,
   input  wire logic       p2_out, p2_oe,
   output wire logic [7:0] p0_in,
   output wire logic       p2_in
);
   // Device drive wins, else board pull-down, else pull-up
   assign p0_in = (p0_oe & p0_out) | (~p0_oe & ~pull_en);
   assign p2_in = p2_oe ? p2_out : 1'h1;
endmodule // pin_board
`default_nettype wire

// *** pin_sync.v ***
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 8
) (
   input  wire             clk,
   input  wire             rst,
   input  wire             ce,
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);
   reg [WIDTH-1:0] stage_ff;
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         stage_ff <= {WIDTH{1'b0}};
         dout     <= {WIDTH{1'b0}};
      end else if (ce) begin
         stage_ff <= din;
         dout     <= stage_ff;
      end
   end
endmodule // pin_sync
`default_nettype wire
